//--- verilog/phy_cfg_pkg.sv
// Functional notes
// - mac port control bits 15:8 and 2 ignore writes, read zero
// - bit 7 enables mac port; resets 1 or from strap by variant
// - bits 6:5 set receive fifo half level, reset 2'b10
// - bits 4:3 set transmit fifo half level, reset 2'b10
// - bit 1 shifts transmit clock against data, reset clear
// - bit 0 shifts receive clock against data, reset clear
// - second register bit 4 bypasses async fifo; other bits read zero
// - timeout enabled: receive frame longer than 1.5 ms is cut off
// - bits 10:7 set unlock recovery timeout in ms, reset 4'hf
// - bit 6 forces good 100 Mb/s link indication
// - bit 5 selects enhanced ternary detection, reset one
// - bit 4 selects enhanced gap detection, reset clear
// - bit 3 bypasses receive block decoder
// - bit 2 turns off transmit scrambler
// - bit 1 enables odd nibble detection
// - bit 0 enables early receive valid
package phy_cfg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] MAC_PORT_CONTROL_ADDR = 5'h12;
    localparam logic [ADDR_W-1:0] MAC_PORT_CONTROL_TWO_ADDR = 5'h13;
    localparam logic [ADDR_W-1:0] FAST_ETH_CONFIG_ADDR = 5'h03;
    localparam logic [6:0] MAC_PORT_CONTROL_REG = 7'h32;
    localparam logic [6:0] FAST_ETH_CONFIG_REG = 7'h43;
    localparam logic [6:0] MAC_PORT_CONTROL_TWO_REG = 7'h33;
    // mac port control fields
    localparam int MPC_EN_BIT = 7;
    localparam int MPC_RX_LO = 5;
    localparam int MPC_TX_LO = 3;
    localparam int MPC_TXD_BIT = 1;
    localparam int MPC_RXD_BIT = 0;
    localparam logic [1:0] HALF_LEVEL_RST = 2'h2;
    localparam int MPC2_BYP_BIT = 4;
    // fast ethernet config fields
    localparam int FEC_TO_OFF_BIT = 11;
    localparam int FEC_TO_LO = 7;
    localparam int FEC_FORCE_BIT = 6;
    localparam int FEC_TERN_BIT = 5;
    localparam int FEC_GAP_BIT = 4;
    localparam int FEC_DEC_BIT = 3;
    localparam int FEC_SCR_BIT = 2;
    localparam int FEC_ODD_BIT = 1;
    localparam int FEC_EARLY_BIT = 0;
    localparam logic [3:0] UNSCRAMBLE_TIMEOUT_RST = 4'hf;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_LIMIT_US10 = 15;
    localparam int FRAME_LIMIT_CYC = FRAME_LIMIT_US10 * 100 * 1000 / (10 * CLK_PERIOD_NS) * 10;
    localparam int MS_CYC = 1000000 / CLK_PERIOD_NS;
endpackage

//--- verilog/phy_cfg_timer.sv
`timescale 1ns/1ps
// frame length guard; counts while a receive frame is active
module phy_cfg_timer
    import phy_cfg_pkg::*;
#(
    parameter int LIMIT = FRAME_LIMIT_CYC
) (
    input wire logic core_clk, // clock
    input wire logic arst_n, // async reset
    input wire logic frame_active, // receive frame in progress
    input wire logic guard_on, // guard enabled
    output logic overrun // frame exceeded limit
);
    logic [31:0] count;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 32'h0;
        end else if (!frame_active) begin
            count <= 32'h0;
        end else if (count < 32'(LIMIT)) begin
            count <= count + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun <= 1'b0;
        end else begin
            overrun <= guard_on && frame_active && (count >= 32'(LIMIT));
        end
    end
endmodule

//--- verilog/phy_mac_port_and_fast_eth_config.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// ****************************************
// register bank and its steering outputs
// ****************************************
module phy_mac_port_and_fast_eth_config
    import phy_cfg_pkg::*;
#(
    parameter bit STRAP_VARIANT = 1'b0, // 1: enable comes from strap
    parameter int FRAME_LIMIT = FRAME_LIMIT_CYC,
    parameter int ONE_MS = MS_CYC
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic [ADDR_W-1:0] addr, // register address
    input wire logic [DATA_W-1:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [DATA_W-1:0] rdata, // read data, cycle after rd
    input wire logic mac_enable_strap, // enable strap pin
    input wire logic rx_frame_active, // receive frame in progress
    input wire logic descrambler_locked, // descrambler lock from pcs
    output logic mac_port_enable, // mac interface enabled
    output logic [1:0] rx_fifo_half_level, // rx fifo threshold
    output logic [1:0] tx_fifo_half_level, // tx fifo threshold
    output logic tx_clk_shift, // shift tx clock
    output logic rx_clk_shift, // shift rx clock
    output logic async_fifo_bypass, // bypass async fifo
    output logic unscramble_timeout_off, // timeout disabled
    output logic [3:0] unscramble_timeout_ms, // unlock recovery ms
    output logic force_link_good, // forced 100 Mb/s link
    output logic enhanced_ternary_detect, // ternary detect mode
    output logic enhanced_gap_detect, // gap detect mode
    output logic rx_block_decoder_bypass, // decoder bypass
    output logic scrambler_off, // scrambler disabled
    output logic odd_nibble_detect, // odd nibble detect on
    output logic early_receive_valid, // early rx valid
    output logic rx_frame_abort, // cut off over-long frame
    output logic unlock_recovery_expired // unlock persisted past timeout
);
    // ****************************************
    // strap capture after reset release
    // ****************************************
    logic strap_s1, strap_s2, strap_taken, strap_v1, strap_v2;
    logic [DATA_W-1:0] mpc, mpc2, fec;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            strap_s1 <= mac_enable_strap;
            strap_s2 <= strap_s1;
        end
    end

    // load window stays open until the second stage holds the pin, not its reset zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_v1 <= 1'b0;
            strap_v2 <= 1'b0;
            strap_taken <= 1'b0;
        end else begin
            strap_v1 <= 1'b1;
            strap_v2 <= strap_v1;
            strap_taken <= strap_v2;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    logic wr_mpc, wr_mpc2, wr_fec;
    assign wr_mpc = wr && addr == MAC_PORT_CONTROL_ADDR;
    assign wr_mpc2 = wr && addr == MAC_PORT_CONTROL_TWO_ADDR;
    assign wr_fec = wr && addr == FAST_ETH_CONFIG_ADDR;

    logic en_bit;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_bit <= 1'b1;
        end else if (wr_mpc) begin
            en_bit <= wdata[MPC_EN_BIT];
        end else if (STRAP_VARIANT && !strap_taken) begin
            en_bit <= strap_s2;
        end
    end

    logic [1:0] rx_lvl, tx_lvl;
    logic txd, rxd, byp;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_lvl <= HALF_LEVEL_RST;
            tx_lvl <= HALF_LEVEL_RST;
            txd <= 1'b0;
            rxd <= 1'b0;
        end else if (wr_mpc) begin
            rx_lvl <= wdata[MPC_RX_LO +: 2];
            tx_lvl <= wdata[MPC_TX_LO +: 2];
            txd <= wdata[MPC_TXD_BIT];
            rxd <= wdata[MPC_RXD_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            byp <= 1'b0;
        end else if (wr_mpc2) begin
            byp <= wdata[MPC2_BYP_BIT];
        end
    end

    logic [11:0] fec_bits;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fec_bits <= {1'b0, UNSCRAMBLE_TIMEOUT_RST, 7'h20};
        end else if (wr_fec) begin
            fec_bits <= wdata[11:0];
        end
    end

    // reserved bits are never stored, so they read zero
    always_comb begin
        mpc = '0;
        mpc[MPC_EN_BIT] = en_bit;
        mpc[MPC_RX_LO +: 2] = rx_lvl;
        mpc[MPC_TX_LO +: 2] = tx_lvl;
        mpc[MPC_TXD_BIT] = txd;
        mpc[MPC_RXD_BIT] = rxd;
        mpc2 = '0;
        mpc2[MPC2_BYP_BIT] = byp;
        fec = {4'h0, fec_bits};
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                MAC_PORT_CONTROL_ADDR: rdata <= mpc;
                MAC_PORT_CONTROL_TWO_ADDR: rdata <= mpc2;
                FAST_ETH_CONFIG_ADDR: rdata <= fec;
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ****************************************
    // steering outputs
    // ****************************************
    assign mac_port_enable = en_bit;
    assign rx_fifo_half_level = rx_lvl;
    assign tx_fifo_half_level = tx_lvl;
    assign tx_clk_shift = txd;
    assign rx_clk_shift = rxd;
    assign async_fifo_bypass = byp;
    assign unscramble_timeout_off = fec_bits[FEC_TO_OFF_BIT];
    assign unscramble_timeout_ms = fec_bits[FEC_TO_LO +: 4];
    assign force_link_good = fec_bits[FEC_FORCE_BIT];
    assign enhanced_ternary_detect = fec_bits[FEC_TERN_BIT];
    assign enhanced_gap_detect = fec_bits[FEC_GAP_BIT];
    assign rx_block_decoder_bypass = fec_bits[FEC_DEC_BIT];
    assign scrambler_off = fec_bits[FEC_SCR_BIT];
    assign odd_nibble_detect = fec_bits[FEC_ODD_BIT];
    assign early_receive_valid = fec_bits[FEC_EARLY_BIT];

    // ****************************************
    // frame guard and unlock recovery timer
    // ****************************************
    logic frame_s1, frame_s2, lock_s1, lock_s2;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_s1 <= 1'b0;
            frame_s2 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            frame_s1 <= rx_frame_active;
            frame_s2 <= frame_s1;
            lock_s1 <= descrambler_locked;
            lock_s2 <= lock_s1;
        end
    end

    // set state of the disable bit is read as guard off
    phy_cfg_timer #(
        .LIMIT(FRAME_LIMIT)
    ) u_guard (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .frame_active(frame_s2),
        .guard_on(!fec_bits[FEC_TO_OFF_BIT]),
        .overrun(rx_frame_abort)
    );

    logic [31:0] ms_div;
    logic [3:0] ms_count;
    logic ms_tick;
    assign ms_tick = ms_div == 32'(ONE_MS - 1);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ms_div <= 32'h0;
        end else if (lock_s2 || ms_tick) begin
            ms_div <= 32'h0;
        end else begin
            ms_div <= ms_div + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ms_count <= 4'h0;
        end else if (lock_s2) begin
            ms_count <= 4'h0;
        end else if (ms_tick && ms_count != 4'hf) begin
            ms_count <= ms_count + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            unlock_recovery_expired <= 1'b0;
        end else begin
            unlock_recovery_expired <= !lock_s2 && ms_count >= unscramble_timeout_ms;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_reserved_zero;
        @(posedge core_clk) disable iff (!arst_n)
        rd && addr == MAC_PORT_CONTROL_ADDR |=> rdata[15:8] == 8'h0 && !rdata[2];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_en_write;
        @(posedge core_clk) disable iff (!arst_n)
        wr_mpc |=> mac_port_enable == $past(wdata[MPC_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not written");

    property p_rx_lvl;
        @(posedge core_clk) disable iff (!arst_n)
        wr_mpc |=> rx_fifo_half_level == $past(wdata[6:5]);
    endproperty
    a_rx_lvl: assert property (p_rx_lvl) else $error("rx level wrong");

    property p_tx_lvl;
        @(posedge core_clk) disable iff (!arst_n)
        wr_mpc |=> tx_fifo_half_level == $past(wdata[4:3]);
    endproperty
    a_tx_lvl: assert property (p_tx_lvl) else $error("tx level wrong");

    property p_clk_shift;
        @(posedge core_clk) disable iff (!arst_n)
        wr_mpc |=> tx_clk_shift == $past(wdata[1]) && rx_clk_shift == $past(wdata[0]);
    endproperty
    a_clk_shift: assert property (p_clk_shift) else $error("clock shift wrong");

    property p_bypass_read;
        @(posedge core_clk) disable iff (!arst_n)
        rd && addr == MAC_PORT_CONTROL_TWO_ADDR |=> rdata == {11'h0, async_fifo_bypass, 4'h0};
    endproperty
    a_bypass_read: assert property (p_bypass_read) else $error("bypass readback wrong");

    property p_guard_off;
        @(posedge core_clk) disable iff (!arst_n)
        unscramble_timeout_off ##1 unscramble_timeout_off |-> !rx_frame_abort;
    endproperty
    a_guard_off: assert property (p_guard_off) else $error("abort while guard off");

    property p_fec_read;
        @(posedge core_clk) disable iff (!arst_n)
        rd && addr == FAST_ETH_CONFIG_ADDR && !wr |=> rdata[11:0] == $past(fec_bits);
    endproperty
    a_fec_read: assert property (p_fec_read) else $error("config readback wrong");
endmodule

//--- bench/pcs_model.sv
`timescale 1ns/1ps
// ****************************************
// receive path stand-in driving frame and lock levels
// ****************************************
module pcs_model (
    input wire logic core_clk, // clock
    input wire logic arst_n, // async reset
    input wire logic frame_req, // start one frame
    input wire logic [7:0] frame_len, // frame length in cycles
    input wire logic lock_req, // lock level to present
    output logic rx_frame_active, // frame in progress
    output logic descrambler_locked // lock level
);
    logic [7:0] left;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            left <= 8'h00;
        end else if (frame_req) begin
            left <= frame_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign rx_frame_active = (left != 8'h00);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            descrambler_locked <= 1'b0;
        end else begin
            descrambler_locked <= lock_req;
        end
    end
endmodule

//--- bench/phy_mac_port_and_fast_eth_config_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", nm, e, g); n_fail++; end end
module phy_mac_port_and_fast_eth_config_tb_top;
    import phy_cfg_pkg::*;
    logic core_clk, arst_n, wr, rd, frame_req, lock_req, mac_enable_strap;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, last_rd, mpc, mpc2, fec;
    logic [7:0] frame_len;
    logic rx_frame_active, descrambler_locked, seen_abort, seen_exp, strap_enable;
    logic mac_port_enable, tx_clk_shift, rx_clk_shift, async_fifo_bypass, unscramble_timeout_off;
    logic force_link_good, enhanced_ternary_detect, enhanced_gap_detect, rx_block_decoder_bypass;
    logic scrambler_off, odd_nibble_detect, early_receive_valid, rx_frame_abort, unlock_recovery_expired;
    logic [1:0] rx_fifo_half_level, tx_fifo_half_level;
    logic [3:0] unscramble_timeout_ms;
    logic [4:0] amap [5];
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed;

    // shortened counts keep the run small
    phy_mac_port_and_fast_eth_config #(.STRAP_VARIANT(1'b0), .FRAME_LIMIT(50), .ONE_MS(10))
    phy_mac_port_and_fast_eth_config_inst (.core_clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
        .mac_enable_strap, .rx_frame_active, .descrambler_locked, .mac_port_enable,
        .rx_fifo_half_level, .tx_fifo_half_level, .tx_clk_shift, .rx_clk_shift, .async_fifo_bypass,
        .unscramble_timeout_off, .unscramble_timeout_ms, .force_link_good, .enhanced_ternary_detect,
        .enhanced_gap_detect, .rx_block_decoder_bypass, .scrambler_off, .odd_nibble_detect,
        .early_receive_valid, .rx_frame_abort, .unlock_recovery_expired);
    // second copy takes its enable from the strap pin
    phy_mac_port_and_fast_eth_config #(.STRAP_VARIANT(1'b1), .FRAME_LIMIT(50), .ONE_MS(10))
    phy_mac_port_and_fast_eth_config_strap_inst (.core_clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata(),
        .mac_enable_strap, .rx_frame_active, .descrambler_locked, .mac_port_enable(strap_enable),
        .rx_fifo_half_level(), .tx_fifo_half_level(), .tx_clk_shift(), .rx_clk_shift(), .async_fifo_bypass(),
        .unscramble_timeout_off(), .unscramble_timeout_ms(), .force_link_good(), .enhanced_ternary_detect(),
        .enhanced_gap_detect(), .rx_block_decoder_bypass(), .scrambler_off(), .odd_nibble_detect(),
        .early_receive_valid(), .rx_frame_abort(), .unlock_recovery_expired());
    pcs_model pcs_model_inst (.core_clk, .arst_n, .frame_req, .frame_len, .lock_req,
        .rx_frame_active, .descrambler_locked);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results;
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    // ****************************************
    // bus cycles and expectations
    // ****************************************
    // each call drives one cycle; rdata of the previous cycle is caught 1 ns after the clock edge
    task automatic cyc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        #1 last_rd = rdata;
        seen_abort |= rx_frame_abort;
        seen_exp |= unlock_recovery_expired;
        @(posedge core_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 5'h00, 16'h0000);
    endtask

    function automatic logic [15:0] exp_rd(input logic [4:0] a);
        if (a == MAC_PORT_CONTROL_ADDR) return mpc;
        if (a == MAC_PORT_CONTROL_TWO_ADDR) return mpc2;
        if (a == FAST_ETH_CONFIG_ADDR) return fec;
        return 16'h0000;
    endfunction

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
        if (a == MAC_PORT_CONTROL_ADDR) mpc = d & 16'h00fb;
        if (a == MAC_PORT_CONTROL_TWO_ADDR) mpc2 = d & 16'h0010;
        if (a == FAST_ETH_CONFIG_ADDR) fec = d & 16'h0fff;
    endtask

    task automatic rd_chk(input logic [4:0] a);
        cyc(1'b0, 1'b1, a, 16'h0000);
        cyc(1'b0, 1'b0, 5'h00, 16'h0000);
        `CHK("rdata", exp_rd(a), last_rd)
    endtask

    task automatic chk_outs;
        `CHK("mpc_out", mpc[7:0], {mac_port_enable, rx_fifo_half_level, tx_fifo_half_level, 1'b0, tx_clk_shift, rx_clk_shift})
        `CHK("bypass_out", mpc2[4], async_fifo_bypass)
        `CHK("fec_out", fec[11:0], {unscramble_timeout_off, unscramble_timeout_ms, force_link_good, enhanced_ternary_detect, enhanced_gap_detect, rx_block_decoder_bypass, scrambler_off, odd_nibble_detect, early_receive_valid})
    endtask

    task automatic run_frame(input logic [7:0] len, input logic exp);
        frame_len <= len;
        frame_req <= 1'b1;
        idle(1);
        frame_req <= 1'b0;
        seen_abort = 1'b0;
        idle(len + 10);
        `CHK("frame_abort", exp, seen_abort)
        `CHK("abort_clear", 1'b0, rx_frame_abort)
    endtask

    task automatic unlock(input int n, input logic exp);
        lock_req <= 1'b0;
        seen_exp = 1'b0;
        idle(n);
        lock_req <= 1'b1;
        idle(8);
        `CHK("unlock_expired", exp, seen_exp)
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int idx;
        logic [15:0] d;
        seed = 32'h33258b4e;
        amap = '{MAC_PORT_CONTROL_ADDR, MAC_PORT_CONTROL_TWO_ADDR, FAST_ETH_CONFIG_ADDR, 5'h1f, 5'h00};
        {wr, rd, frame_req, mac_enable_strap, seen_abort, seen_exp} = 6'h00;
        mac_enable_strap = 1'b1;
        addr = 5'h00;
        wdata = 16'h0000;
        frame_len = 8'h00;
        lock_req = 1'b1;
        arst_n = 1'b0;
        mpc = 16'h00d0;
        mpc2 = 16'h0000;
        fec = 16'h07a0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        idle(3);
        chk_outs();
        foreach (amap[i]) rd_chk(amap[i]);
        `CHK("strap_enable", 1'b1, strap_enable)
        // all ones then all zeros, back to back, to expose reserved bits
        d = 16'hffff;
        repeat (2) begin
            foreach (amap[i]) wr_reg(amap[i], d);
            foreach (amap[i]) rd_chk(amap[i]);
            chk_outs();
            d = 16'h0000;
        end
        wr_reg(FAST_ETH_CONFIG_ADDR, 16'h0100);
        run_frame(8'd30, 1'b0);
        run_frame(8'd80, 1'b1);
        unlock(10, 1'b0);
        unlock(40, 1'b1);
        wr_reg(FAST_ETH_CONFIG_ADDR, 16'h0800);
        run_frame(8'd80, 1'b0);
        unlock(3, 1'b1);
        repeat (40) begin
            idx = int'({$random(seed)} % 5);
            d = $random(seed);
            wr_reg(amap[idx], d);
            rd_chk(amap[idx]);
            chk_outs();
        end
        results();
    end
endmodule
